// >>> core/scan_bus_sequencer.sv
// signal-conditioning end of the shared analog scan bus: counter, table, line drive
`timescale 1ns/10ps
module scan_bus_sequencer #(
    parameter int ADDR_W     = scan_bus_pkg::ADDR_W_STD,
    parameter int STEP_WIDTH = scan_bus_pkg::STEP_WIDTH
) (
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    input  wire logic                          strobeIn,
    input  wire logic                          tableWrite,
    input  wire logic [ADDR_W-1:0]             tableAddr,
    input  scan_bus_pkg::scan_entry_s          tableData,
    output logic [scan_bus_pkg::NUM_LINES-1:0] lineEnable,
    output logic [scan_bus_pkg::CHAN_W-1:0]    selChannel,
    output logic [ADDR_W-1:0]                  addrCount
);

    // **********************************
    // sizes
    // **********************************
    // one entry per counter value, so the counter can never run off the table
    localparam int DEPTH = 1 << ADDR_W;

    // **********************************
    // types
    // **********************************
    // drive lines, channel number, counter and the whole table
    typedef logic [scan_bus_pkg::NUM_LINES-1:0]   lines_t;
    typedef logic [scan_bus_pkg::CHAN_W-1:0]      chan_t;
    typedef logic [ADDR_W-1:0]                    addr_t;
    typedef scan_bus_pkg::scan_entry_s [DEPTH-1:0] entries_t;

    // **********************************
    // state
    // **********************************
    // table shares the register but not the reset
    typedef struct packed {
        entries_t entries;
        addr_t    addr;
        lines_t   lines;
        chan_t    chan;
    } seq_s;

    // helpers below, save s_q and evt, are all filled at the top of the next-state process
    seq_s                      s_q;
    seq_s                      s_d;
    scan_bus_pkg::strobe_evt_s evt;
    scan_bus_pkg::scan_entry_s cur;
    addr_t                     nextAddr;
    logic                      moved;
    lines_t                    driveNext;
    chan_t                     chanNext;

    // **********************************
    // line decode
    // **********************************
    // one-hot line select from the two low channel bits, a to d
    function automatic lines_t line_of(
        input chan_t ch
    );
        lines_t r;
        case (ch[scan_bus_pkg::LINE_W-1:0])
            2'h0: begin
                r = lines_t'(4'h1);
            end
            2'h1: begin
                r = lines_t'(4'h2);
            end
            2'h2: begin
                r = lines_t'(4'h4);
            end
            2'h3: begin
                r = lines_t'(4'h8);
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    // a disabled entry still steps but drives nothing
    function automatic lines_t drive_of(
        input scan_bus_pkg::scan_entry_s e
    );
        lines_t r;
        r = '0;
        if (e.enable) begin
            r = line_of(e.channel);
        end
        return r;
    endfunction

    // **********************************
    // counter
    // **********************************
    // wraps at the table end; the wide strobe restarts the frame
    function automatic addr_t step_addr(
        input addr_t                     a,
        input scan_bus_pkg::strobe_evt_s e
    );
        addr_t r;
        case ({e.frame, e.step})
            2'b10: begin
                r = '0;
            end
            2'b01: begin
                r = a + addr_t'(1);
            end
            default: begin
                r = a;
            end
        endcase
        return r;
    endfunction

    // any classified strobe moves the drive; idle cycles leave it standing
    function automatic logic has_event(
        input scan_bus_pkg::strobe_evt_s e
    );
        return e.step | e.frame;
    endfunction

    // **********************************
    // scan table
    // **********************************
    // one entry replaced per write strobe; the rest hold
    function automatic entries_t write_entry(
        input entries_t                  tbl,
        input logic                      we,
        input addr_t                     idx,
        input scan_bus_pkg::scan_entry_s d
    );
        entries_t r;
        r = tbl;
        if (we) begin
            r[idx] = d;
        end
        return r;
    endfunction

    // read at the counter value the next edge will hold
    function automatic scan_bus_pkg::scan_entry_s entry_at(
        input entries_t tbl,
        input addr_t    idx
    );
        return tbl[idx];
    endfunction

    // **********************************
    // reset
    // **********************************
    // counter and drive cleared; table kept, so a bus reset needs no reload
    function automatic seq_s reset_state(
        input seq_s s
    );
        seq_s r;
        r       = s;
        r.addr  = '0;
        r.lines = '0;
        r.chan  = '0;
        return r;
    endfunction

    // **********************************
    // strobe width classifier
    // **********************************
    // events arrive on the same edge that first sees the strobe low
    strobe_classifier #(
        .STEP_WIDTH (STEP_WIDTH)
    ) u_strobe_classifier (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .strobeIn (strobeIn),
        .evt      (evt)
    );

    // **********************************
    // next state
    // **********************************
    // ordering of entries is software's job; hardware trusts the low bits
    always_comb begin
        s_d       = s_q;
        nextAddr  = step_addr(s_q.addr, evt);
        cur       = entry_at(s_q.entries, nextAddr);
        moved     = has_event(evt);
        driveNext = drive_of(cur);
        chanNext  = cur.channel;

        s_d.entries = write_entry(s_q.entries, tableWrite, tableAddr, tableData);
        s_d.addr    = nextAddr;

        // drive moves only on a strobe, so loading the table never disturbs the bus
        if (moved) begin
            s_d.chan  = chanNext;
            s_d.lines = driveNext;
        end

        // writes still land during reset
        if (sys_rst) begin
            s_d = reset_state(s_d);
        end
    end

    // **********************************
    // state register
    // **********************************
    // table flops ride here too; no enable, every flop runs each edge
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // **********************************
    // outputs
    // **********************************
    assign lineEnable = s_q.lines;
    assign selChannel = s_q.chan;
    assign addrCount  = s_q.addr;

endmodule

// >>> core/scan_bus_pkg.sv
// constants and types shared by the scan-bus sequencer files
package scan_bus_pkg;

    // **********************************
    // sizes and timing
    // **********************************
    localparam int ADDR_W_STD   = 8;
    localparam int ADDR_W_LARGE = 11;
    localparam int CHAN_W       = 11;
    localparam int NUM_LINES    = 4;
    localparam int LINE_W       = 2;
    // strobe high time in clocks; wide strobe is at least twice this
    localparam int STEP_WIDTH   = 4;
    localparam int WIDTH_CNT_W  = 8;

    // **********************************
    // types
    // **********************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIGH = 3'b010,
        ST_WIDE = 3'b100
    } strobe_state_e;

    typedef struct packed {
        logic              enable;
        logic [CHAN_W-1:0] channel;
    } scan_entry_s;

    typedef struct packed {
        logic             step;
        logic             frame;
    } strobe_evt_s;

endpackage

// >>> core/strobe_classifier.sv
// classifies bus timing strobes as stepping or frame-start by their width
`timescale 1ns/10ps
module strobe_classifier #(
    parameter int STEP_WIDTH = scan_bus_pkg::STEP_WIDTH
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 strobeIn,
    output scan_bus_pkg::strobe_evt_s evt
);

    // **********************************
    // state
    // **********************************
    typedef struct packed {
        scan_bus_pkg::strobe_state_e             st;
        logic [scan_bus_pkg::WIDTH_CNT_W-1:0]    width;
        scan_bus_pkg::strobe_evt_s               evt;
    } cls_s;

    localparam logic [scan_bus_pkg::WIDTH_CNT_W-1:0] WIDE_LIMIT =
        scan_bus_pkg::WIDTH_CNT_W'(2 * STEP_WIDTH - 1);

    cls_s s_q;
    cls_s s_d;

    // events fire at the falling edge, so width is known before acting
    always_comb begin
        s_d = s_q;
        s_d.evt = '0;
        case (s_q.st)
            scan_bus_pkg::ST_IDLE: begin
                if (strobeIn) begin
                    s_d.st = scan_bus_pkg::ST_HIGH;
                    s_d.width = 8'h01;
                end
            end
            scan_bus_pkg::ST_HIGH: begin
                if (!strobeIn) begin
                    s_d.st = scan_bus_pkg::ST_IDLE;
                    s_d.evt.step = 1'b1;
                end else if (s_q.width >= WIDE_LIMIT) begin
                    s_d.st = scan_bus_pkg::ST_WIDE;
                end else begin
                    s_d.width = s_q.width + 8'h01;
                end
            end
            scan_bus_pkg::ST_WIDE: begin
                if (!strobeIn) begin
                    s_d.st = scan_bus_pkg::ST_IDLE;
                    s_d.evt.frame = 1'b1;
                end
            end
            default: begin
                s_d.st = scan_bus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '{st: scan_bus_pkg::ST_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign evt = s_q.evt;

endmodule

// >>> test/scan_bus_seq_chk.sv
// port checks for the scan-bus sequencer
`timescale 1ns/10ps
module scan_bus_seq_chk #(
    parameter int ADDR_W     = 8,
    parameter int STEP_WIDTH = 4
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              strobeIn,
    input wire logic [3:0]        lineEnable,
    input wire logic [10:0]       selChannel,
    input wire logic [ADDR_W-1:0] addrCount
);
    // ****
    // strobe run length
    // ****
    logic [7:0] hiCnt_q;
    always_ff @(posedge clock)
        hiCnt_q <= (sys_rst || !strobeIn) ? 8'h00 : hiCnt_q + {7'h0, hiCnt_q != 8'hff};
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    one_line_a: assert property ($onehot0(lineEnable)) else $error("two lines");
    line_map_a: assert property (|lineEnable |-> lineEnable == 4'h1 << selChannel[1:0])
        else $error("wrong line");
    step_inc_a: assert property (!$stable(addrCount) |->
        addrCount == $past(addrCount) + 1'b1 || addrCount == '0) else $error("jump");
    quiet_cnt_a: assert property ($stable(strobeIn)[*4] |-> $stable(addrCount))
        else $error("step without strobe");
    quiet_drv_a: assert property ($stable(strobeIn)[*4] |-> $stable(selChannel))
        else $error("entry moved");
    step_fire_a: assert property ($fell(strobeIn) && hiCnt_q < 2 * STEP_WIDTH
        |-> ##[1:3] !$stable(addrCount)) else $error("step lost");
    frame_clr_a: assert property ($fell(strobeIn) && hiCnt_q >= 2 * STEP_WIDTH
        |-> ##[1:3] addrCount == '0) else $error("frame not cleared");
    rst_zero_a: assert property (disable iff (1'b0) sys_rst |=>
        addrCount == '0 && lineEnable == '0 && selChannel == '0) else $error("reset");
    cover property ($fell(strobeIn) && hiCnt_q >= 2 * STEP_WIDTH);
    cover property ($past(addrCount) == '1 && addrCount == '0);
    cover property (!(|lineEnable) && !$stable(addrCount));
endmodule
bind scan_bus_sequencer scan_bus_seq_chk #(.ADDR_W(ADDR_W), .STEP_WIDTH(STEP_WIDTH)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .strobeIn(strobeIn),
    .lineEnable(lineEnable), .selChannel(selChannel), .addrCount(addrCount));

// >>> test/adc_strobe_model.sv
// converter-side model that makes the scan strobes
`timescale 1ns/10ps
module adc_strobe_model (
    input  wire logic clock,
    output logic      strobeIn
);
    initial strobeIn = 1'b0;
    // double width starts a frame; low gap kept long for settling
    task automatic pulse(input int w);
        @(negedge clock) strobeIn = 1'b1;
        repeat (w) @(negedge clock);
        strobeIn = 1'b0;
        repeat (5) @(negedge clock);
    endtask
endmodule

// >>> test/scan_bus_sequencer_tb.sv
// bench for the scan-bus sequencer
`timescale 1ns/10ps
module scan_bus_sequencer_tb;
    localparam int SW = 4;
    logic clock, sys_rst, strobeIn, tableWrite;
    logic [7:0] tableAddr, addrCount;
    logic [3:0] lineEnable;
    logic [10:0] selChannel;
    scan_bus_pkg::scan_entry_s tableData, tbl [256];
    int n_mismatch = 0, check_count = 0;
    adc_strobe_model u_adc_strobe_model (.clock(clock), .strobeIn(strobeIn));
    scan_bus_sequencer #(.ADDR_W(8), .STEP_WIDTH(SW)) u_scan_bus_sequencer (
        .clock(clock), .sys_rst(sys_rst), .strobeIn(strobeIn), .tableWrite(tableWrite),
        .tableAddr(tableAddr), .tableData(tableData), .lineEnable(lineEnable),
        .selChannel(selChannel), .addrCount(addrCount));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ****
    // tasks
    // ****
    task automatic chk(input logic [7:0] a);
        check_count++;
        if (addrCount !== a || selChannel !== tbl[a].channel || lineEnable !==
            (tbl[a].enable ? 4'h1 << tbl[a].channel[1:0] : 4'h0)) begin
            n_mismatch++;
            $display("Error %0t addr %h line %h", $time, addrCount, lineEnable);
        end
    endtask
    task automatic chk_idle;
        check_count++;
        if (addrCount !== 8'h00 || lineEnable !== 4'h0 || selChannel !== 11'h000) begin
            n_mismatch++;
            $display("Error %0t outputs not idle", $time);
        end
    endtask
    // low channel bits cycle 00..11; some entries left disabled
    task automatic load_table;
        for (int i = 0; i < 256; i++) begin
            @(negedge clock);
            tbl[i] = '{enable: ~(i[2] & i[4]), channel: 11'(i)};
            tableWrite = 1'b1;
            tableAddr = 8'(i);
            tableData = tbl[i];
        end
        @(negedge clock) tableWrite = 1'b0;
        chk_idle();
        $display("table loaded");
    endtask
    task automatic test_scan;
        u_adc_strobe_model.pulse(2 * SW);
        chk(8'h00);
        for (int i = 1; i <= 256; i++) begin
            u_adc_strobe_model.pulse(SW);
            chk(8'(i));
        end
        $display("full scan done");
    endtask
    task automatic test_frame;
        u_adc_strobe_model.pulse(2 * SW - 1);
        chk(8'h01);
        u_adc_strobe_model.pulse(SW);
        u_adc_strobe_model.pulse(2 * SW);
        chk(8'h00);
        $display("mid-scan frame done");
    endtask
    task automatic test_reset;
        u_adc_strobe_model.pulse(SW);
        chk(8'h01);
        sys_rst = 1'b1;
        @(negedge clock) sys_rst = 1'b0;
        @(negedge clock);
        chk_idle();
        u_adc_strobe_model.pulse(SW);
        chk(8'h01);
        $display("mid-run reset done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        tableWrite = 1'b0;
        tableAddr = 8'h00;
        tableData = '0;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        load_table();
        test_scan();
        test_frame();
        test_reset();
        end_of_test();
    end
endmodule
